/* File: pkg/scp_pkg.sv */
package scp_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SRC_HZ = 14_318_180;
  localparam int unsigned SRC_DIV = 12;
  // System clocks per counting tick, rounded to nearest
  localparam int unsigned TICK_DIV = (CLK_HZ * SRC_DIV + SRC_HZ / 2) / SRC_HZ;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_CH0 = 8'h40;
  localparam logic [7:0] IDX_CH1 = 8'h41;
  localparam logic [7:0] IDX_CH2 = 8'h42;
  localparam logic [7:0] IDX_CTRL = 8'h43;
  localparam logic [7:0] IDX_SYS = 8'h61;

  // ------------------------------------------------------------
  // Control word fields and codes
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sel;
    logic [1:0] rw;
    logic [2:0] mode;
    logic bcd;
  } scp_cw_t;
  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] RW_LATCH = 2'h0;
  localparam logic [1:0] RW_LSB = 2'h1;
  localparam logic [1:0] RW_MSB = 2'h2;
  localparam logic [1:0] RW_BOTH = 2'h3;
  localparam logic [1:0] RW_RST = 2'h1;
  localparam logic [2:0] MODE_SW_STROBE = 3'h4;
  localparam logic [2:0] MODE_HW_STROBE = 3'h5;
  localparam logic [2:0] MODE_RST = 3'h0;

  // ------------------------------------------------------------
  // System port bit positions and reset value
  // ------------------------------------------------------------
  localparam int SYS_PAR_ERR = 7;
  localparam int SYS_IO_ERR = 6;
  localparam int SYS_C2_OUT = 5;
  localparam int SYS_REFRESH = 4;
  localparam int SYS_IO_DIS = 3;
  localparam int SYS_PAR_DIS = 2;
  localparam int SYS_SPK = 1;
  localparam int SYS_GATE2 = 0;
  localparam logic [3:0] SYS_CTRL_RST = 4'h0;

  // Decrement by one, binary or four decades
  function automatic logic [15:0] scp_dec(input logic [15:0] v,
                                          input logic bcd);
    logic [15:0] r;
    logic b;
    r = bcd ? v : v - 16'h0001;
    b = bcd;
    for (int i = 0; i < 4; i++) begin
      if (b) begin
        if (v[4*i +: 4] == 4'h0) begin
          r[4*i +: 4] = 4'h9;
        end else begin
          r[4*i +: 4] = v[4*i +: 4] - 4'h1;
          b = 1'b0;
        end
      end
    end
    return r;
  endfunction
endpackage

/* File: tb/scp_status_src.sv */
`timescale 1ns/100ps
`default_nettype none
module scp_status_src (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Requested levels: refresh, bus fault, board parity
  input wire logic [2:0] lvl_in,
  // Status lines toward the port
  output logic ram_parity_err_out,
  output logic io_check_err_out,
  output logic refresh_req_out
);
  // ----------------------------------------------------------
  // Board fault and refresh sources
  // ----------------------------------------------------------
  // Lines move only just after a clock edge, as board logic does
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ram_parity_err_out <= 1'b0;
      io_check_err_out <= 1'b0;
      refresh_req_out <= 1'b0;
    end else begin
      ram_parity_err_out <= lvl_in[0];
      io_check_err_out <= lvl_in[1];
      refresh_req_out <= lvl_in[2];
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_strobe_counter_and_speaker_port.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_strobe_counter_and_speaker_port import scp_pkg::*;;
  // ----------------------------------------------------------
  // Clock, stimulus and counters
  // ----------------------------------------------------------
  localparam int T = 2;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [9:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = '0;
  logic [3:0] be = 4'h1;
  logic [2:0] lvl = '0;
  logic [31:0] rdat;
  logic wait_o, tone, spk, par_en, io_en, par_e, io_e, refr, irq, rfo;
  logic [2:0] outs;
  logic [7:0] q;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;

  // Free-running system clock
  always #20 clk_in = ~clk_in;

  // Channel outputs by channel number
  assign outs = {tone, rfo, irq};

  scp_status_src SRC (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .lvl_in(lvl), .ram_parity_err_out(par_e),
    .io_check_err_out(io_e), .refresh_req_out(refr));

  scp_timer_port #(.TICK_CYCLES(T)) DUT (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wait_o), .ram_parity_err_in(par_e),
    .io_check_err_in(io_e), .refresh_req_in(refr),
    .tick_irq_out(irq), .refresh_tick_out(rfo), .tone_out(tone),
    .speaker_out(spk), .ram_parity_check_en_out(par_en),
    .io_check_en_out(io_en));

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One bus access; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    adr <= {idx, 2'b00};
    rd <= !w;
    wr <= w;
    wdat <= {24'h0, d};
    @(posedge clk_in);
    while (wait_o !== 1'b0) begin
      @(posedge clk_in);
    end
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_in);
  endtask

  // Channel output must not drop during c cycles
  task automatic stay_high(input int c, input int ch = 2);
    int lows;
    lows = 0;
    repeat (c) begin
      @(posedge clk_in);
      if (outs[ch] !== 1'b1) lows++;
    end
    chk(32'(lows), 32'h0, "output dropped");
  endtask

  // Time to the strobe against n ticks, and strobe width of one tick
  task automatic strobe(input int n, input int adj, input int ch = 2);
    int c;
    int w;
    c = 0;
    w = 0;
    while (outs[ch] === 1'b1 && c < 3000) begin
      @(posedge clk_in);
      c++;
    end
    while (outs[ch] !== 1'b1 && w < 100) begin
      @(posedge clk_in);
      w++;
    end
    chk(32'(c >= n*T - adj && c <= (n+1)*T + 4), 32'h1, "high time");
    chk(32'(w), 32'(T), "low time");
  endtask

  // Cycle ceiling against a hang
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_in);
    chk(32'(wait_o), 32'h1, "reset wait");
    chk(32'(spk), 32'h0, "reset speaker");
    chk(32'({par_en, io_en, tone, irq, rfo}), 32'h1f, "reset outs");
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    // System port status and controls
    bus(1'b0, IDX_SYS, 8'h00);
    chk(32'(q), 32'h20, "sys idle");
    lvl <= 3'b111;
    repeat (3) @(posedge clk_in);
    bus(1'b0, IDX_SYS, 8'h00);
    chk(32'(q), 32'hf0, "sys status");
    bus(1'b1, IDX_SYS, 8'hfc);
    bus(1'b0, IDX_SYS, 8'h00);
    chk(32'(q), 32'h3c, "sys disabled");
    chk(32'({par_en, io_en}), 32'h0, "check enables off");
    bus(1'b1, IDX_SYS, 8'h00);
    bus(1'b0, IDX_SYS, 8'h00);
    chk(32'(q), 32'hf0, "sys enabled");
    chk(32'({par_en, io_en}), 32'h3, "check enables on");
    lvl <= 3'b000;
    bus(1'b0, 8'h50, 8'h00);
    chk(32'(q), 32'h0, "unmapped read");
    bus(1'b0, IDX_CTRL, 8'h00);
    chk(32'(q), 32'h0, "control read");
    bus(1'b1, IDX_SYS, 8'h02);
    repeat (2) @(posedge clk_in);
    chk(32'(spk), 32'h1, "speaker on");
    bus(1'b0, IDX_SYS, 8'h00);
    chk(32'(q), 32'h22, "sys speaker bit");
    bus(1'b1, IDX_SYS, 8'h00);
    repeat (2) @(posedge clk_in);
    chk(32'(spk), 32'h0, "speaker off");
    $display("test system port done");
    // Write-triggered strobe on channel 2
    bus(1'b1, IDX_CTRL, 8'h98);
    chk(32'(tone), 32'h1, "mode out high");
    bus(1'b1, IDX_SYS, 8'h01);
    bus(1'b0, IDX_SYS, 8'h00);
    chk(32'(q), 32'h21, "trigger bit");
    stay_high(20);
    bus(1'b1, IDX_CH2, 8'h05);
    strobe(5, 0);
    stay_high(30);
    bus(1'b1, IDX_CH2, 8'h14);
    repeat (10) @(posedge clk_in);
    bus(1'b1, IDX_CH2, 8'h04);
    strobe(4, 0);
    bus(1'b1, IDX_CTRL, 8'hb8);
    bus(1'b1, IDX_CH2, 8'h03);
    stay_high(20);
    bus(1'b1, IDX_CH2, 8'h00);
    strobe(3, 0);
    bus(1'b1, IDX_CTRL, 8'h99);
    bus(1'b1, IDX_CH2, 8'h10);
    strobe(10, 0);
    bus(1'b1, IDX_CTRL, 8'ha8);
    bus(1'b1, IDX_CH2, 8'h01);
    strobe(256, 0);
    $display("test write strobe done");
    // Gate-triggered strobe, usable on channel 2 only
    bus(1'b1, IDX_SYS, 8'h00);
    bus(1'b1, IDX_CTRL, 8'h9a);
    bus(1'b1, IDX_CH2, 8'h04);
    stay_high(40);
    bus(1'b1, IDX_SYS, 8'h01);
    strobe(4, 0);
    bus(1'b1, IDX_SYS, 8'h00);
    bus(1'b1, IDX_SYS, 8'h01);
    bus(1'b1, IDX_CH2, 8'h09);
    strobe(4, 4);
    bus(1'b1, IDX_SYS, 8'h00);
    bus(1'b1, IDX_SYS, 8'h01);
    strobe(9, 0);
    bus(1'b1, IDX_SYS, 8'h00);
    bus(1'b1, IDX_SYS, 8'h01);
    repeat (6) @(posedge clk_in);
    bus(1'b1, IDX_SYS, 8'h00);
    bus(1'b1, IDX_SYS, 8'h01);
    strobe(9, 0);
    $display("test gate strobe done");
    // Write strobe on channel 1, dead trigger on channel 0
    bus(1'b1, IDX_CTRL, 8'h58);
    bus(1'b1, IDX_CH1, 8'h03);
    strobe(3, 0, 1);
    bus(1'b1, IDX_CTRL, 8'h1a);
    bus(1'b1, IDX_CH0, 8'h02);
    stay_high(40, 0);
    $display("test other channels done");
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: verilog/scp_strobe_chan.sv */
`timescale 1ns/100ps
`default_nettype none
module scp_strobe_chan import scp_pkg::*; (
  // Clock, reset and counting tick
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  // Programming
  input wire logic cfg_wr_in,
  input wire scp_cw_t cfg_in,
  input wire logic cnt_wr_in,
  input wire logic [15:0] cnt_in,
  // Trigger and results
  input wire logic gate_in,
  output logic out_out,
  output logic [15:0] count_out
);
  localparam int CHK_SPAN = 64;
  typedef enum logic [1:0] {ST_IDLE, ST_COUNT, ST_LOW} scp_st_t;
  scp_st_t st;
  logic [2:0] mode;
  logic bcd;
  logic [15:0] init;
  logic pend;
  logic armed;
  logic gate_q;
  logic trig;
  logic rise;
  logic load_now;
  logic [15:0] next_cnt;

  // Trigger edge and load decision
  assign rise = gate_in && !gate_q && armed && (mode == MODE_HW_STROBE);
  assign load_now = tick_in &&
    ((mode == MODE_SW_STROBE) ? pend : (trig || rise));
  assign next_cnt = scp_dec(count_out, bcd);

  // Mode, initial count and arming
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode <= MODE_RST;
      bcd <= 1'b0;
      init <= 16'h0000;
      armed <= 1'b0;
      gate_q <= 1'b1;
    end else begin
      gate_q <= gate_in;
      if (cfg_wr_in) begin
        mode <= cfg_in.mode;
        bcd <= cfg_in.bcd;
        armed <= 1'b0;
      end else if (cnt_wr_in) begin
        init <= cnt_in;
        armed <= 1'b1;
      end
    end
  end

  // Pending software load and latched trigger; a new event wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend <= 1'b0;
      trig <= 1'b0;
    end else begin
      pend <= cnt_wr_in || (pend && !tick_in && !cfg_wr_in);
      trig <= rise || (trig && !tick_in && !cfg_wr_in);
    end
  end

  // Counter and output
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= ST_IDLE;
      out_out <= 1'b1;
      count_out <= 16'h0000;
    end else if (cfg_wr_in) begin
      st <= ST_IDLE;
      out_out <= 1'b1;
    end else if (load_now) begin
      // In software strobe mode a write in the load tick itself wins over the stored count
      count_out <= (mode == MODE_SW_STROBE && cnt_wr_in) ?
                   cnt_in : init;
      st <= ST_COUNT;
      out_out <= 1'b1;
    end else if (tick_in) begin
      count_out <= next_cnt;
      unique case (st)
        ST_IDLE: begin
          out_out <= 1'b1;
        end
        ST_COUNT: begin
          if (next_cnt == 16'h0000) begin
            st <= ST_LOW;
            out_out <= 1'b0;
          end
        end
        ST_LOW: begin
          st <= ST_IDLE;
          out_out <= 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence seq_low_pulse;
    (!out_out throughout (##[0:CHK_SPAN] tick_in)) ##1 out_out;
  endsequence

  chk_ctrl_out_high: assert property (cfg_wr_in |=> out_out)
    else $error("output not high after control write");
  chk_low_one_tick: assert property ($fell(out_out) |-> seq_low_pulse)
    else $error("strobe low not exactly one tick");
  chk_load_no_dec: assert property (load_now && !cfg_wr_in |=>
    st == ST_COUNT && out_out)
    else $error("load did not start a high count");
  chk_dec_step: assert property (tick_in && !load_now && !cfg_wr_in |=>
    count_out == scp_dec($past(count_out), bcd))
    else $error("count did not decrement by one");
  chk_hw_write_keep: assert property (mode == MODE_HW_STROBE &&
    cnt_wr_in && !load_now && !cfg_wr_in |=> count_out ==
    ($past(tick_in) ? scp_dec($past(count_out), bcd) : $past(count_out)))
    else $error("count write disturbed count in progress");
  chk_retrig_high: assert property (st == ST_COUNT && load_now &&
    !cnt_wr_in && !cfg_wr_in |=> out_out && count_out == $past(init))
    else $error("retrigger did not reload with output high");
  chk_gate_ignored: assert property (mode == MODE_SW_STROBE &&
    !tick_in && !cfg_wr_in |=> out_out == $past(out_out))
    else $error("output moved without a tick");
endmodule
`default_nettype wire

/* File: verilog/scp_tick_div.sv */
`timescale 1ns/100ps
`default_nettype none
module scp_tick_div import scp_pkg::*; #(
  parameter int unsigned DIV = TICK_DIV
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Counting tick
  output logic tick_out
);
  logic [7:0] cnt;

  // Free running divider, one pulse per period
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 8'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= (cnt == 8'(DIV - 1));
      cnt <= (cnt == 8'(DIV - 1)) ? 8'h00 : cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/scp_timer_port.sv */
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Software strobe: count write starts; high n+1 ticks, low one.
// - Programming software strobe drives output high; trigger input ignored.
// - Count written while counting loads next tick; counting continues.
// - Two-byte count loads only after the second byte.
// - Load tick no decrement; low at zero for one tick, high at wrap.
// - Gate strobe: rising trigger while armed runs high n+1, low one.
// - Gate strobe: mode then count drives output high and arms trigger.
// - Gate strobe: count write mid-cycle waits for next trigger.
// - Trigger stays armed until control word is rewritten.
// - Trigger before zero reloads next tick; output stays high.
// - Counts at 40h-42h read/write, control 43h write-only, system 61h.
// - System bit 7 reads board memory parity error.
// - System bit 6 reads bus I/O or option memory parity error.
// - System bit 5 reads channel 2 output level.
// - System bit 4 reads refresh request activity.
// - System bit 3: 0 enables, 1 disables bus fault checking.
// - System bit 2 written 1 disables board parity checking.
// - System bit 1 ANDed with channel 2 output drives speaker.
// - System bit 0 sets channel 2 trigger level.
// - All channels count on one common divided tick near 1.19 MHz.
// - Each channel counts binary or four decades by control bit 0.
module scp_timer_port import scp_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_DIV
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Avalon-MM slave
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // System status inputs
  input wire logic ram_parity_err_in,
  input wire logic io_check_err_in,
  input wire logic refresh_req_in,
  // Channel outputs and system controls
  output logic tick_irq_out,
  output logic refresh_tick_out,
  output logic tone_out,
  output logic speaker_out,
  output logic ram_parity_check_en_out,
  output logic io_check_en_out
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic tick;
  logic [3:0] sys_ctrl;
  logic [1:0] rw_fmt [3];
  logic wr_hi [3];
  logic rd_hi [3];
  logic [7:0] lsb_hold [3];
  logic cfg_wr [3];
  logic cnt_wr [3];
  logic [15:0] cnt_val [3];
  logic [15:0] count [3];
  logic ch_out [3];
  logic gate [3];
  logic rd_take;
  logic wr_take;
  logic [7:0] wbyte;
  scp_cw_t cw;
  logic [7:0] next_rbyte;
  logic [7:0] sys_read;

  // Byte address match for one register index
  function automatic logic reg_hit(input logic [9:0] a,
                                   input logic [7:0] idx);
    return a == {idx, 2'b00};
  endfunction

  // Channel index for count ports
  function automatic logic [7:0] ch_idx(input int c);
    return IDX_CH0 + 8'(c);
  endfunction

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  assign rd_take = avs_read_in && !avs_waitrequest_out;
  assign wr_take = avs_write_in && !avs_waitrequest_out &&
                   avs_byteenable_in[0];
  assign wbyte = avs_writedata_in[7:0];
  assign cw = scp_cw_t'(wbyte);

  // One wait cycle per request, then the answer cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !((avs_read_in || avs_write_in) &&
                               avs_waitrequest_out);
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // System port status view
  always_comb begin
    sys_read = {4'h0, sys_ctrl};
    sys_read[SYS_PAR_ERR] = ram_parity_err_in &&
                            !sys_ctrl[SYS_PAR_DIS];
    sys_read[SYS_IO_ERR] = io_check_err_in && !sys_ctrl[SYS_IO_DIS];
    sys_read[SYS_C2_OUT] = ch_out[2];
    sys_read[SYS_REFRESH] = refresh_req_in;
  end

  // Address decode of the byte to return; unmapped reads zero
  always_comb begin
    next_rbyte = 8'h00;
    for (int c = 0; c < 3; c++) begin
      if (reg_hit(avs_address_in, ch_idx(c))) begin
        if (rw_fmt[c] == RW_MSB || (rw_fmt[c] == RW_BOTH && rd_hi[c])) begin
          next_rbyte = count[c][15:8];
        end else begin
          next_rbyte = count[c][7:0];
        end
      end
    end
    if (reg_hit(avs_address_in, IDX_SYS)) begin
      next_rbyte = sys_read;
    end
  end

  // Read data captured during the wait cycle, held for the answer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && avs_waitrequest_out) begin
      avs_readdata_out <= {24'h00_0000, next_rbyte};
    end
  end

  // ------------------------------------------------------------
  // Count and control writes
  // ------------------------------------------------------------
  // Strobes towards the channels
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      cfg_wr[c] = wr_take && reg_hit(avs_address_in, IDX_CTRL) &&
                  cw.sel == 2'(c) && cw.rw != RW_LATCH;
      cnt_wr[c] = 1'b0;
      cnt_val[c] = {8'h00, wbyte};
      if (wr_take && reg_hit(avs_address_in, ch_idx(c))) begin
        unique case (rw_fmt[c])
          RW_MSB: begin
            cnt_wr[c] = 1'b1;
            cnt_val[c] = {wbyte, 8'h00};
          end
          RW_BOTH: begin
            cnt_wr[c] = wr_hi[c];
            cnt_val[c] = {wbyte, lsb_hold[c]};
          end
          default: begin
            cnt_wr[c] = 1'b1;
          end
        endcase
      end
    end
  end

  // Byte order state per channel
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int c = 0; c < 3; c++) begin
        rw_fmt[c] <= RW_RST;
        wr_hi[c] <= 1'b0;
        rd_hi[c] <= 1'b0;
        lsb_hold[c] <= 8'h00;
      end
    end else begin
      for (int c = 0; c < 3; c++) begin
        if (cfg_wr[c]) begin
          rw_fmt[c] <= cw.rw;
          wr_hi[c] <= 1'b0;
          rd_hi[c] <= 1'b0;
        end else begin
          if (wr_take && reg_hit(avs_address_in, ch_idx(c)) &&
              rw_fmt[c] == RW_BOTH) begin
            wr_hi[c] <= !wr_hi[c];
            if (!wr_hi[c]) begin
              lsb_hold[c] <= wbyte;
            end
          end
          if (rd_take && reg_hit(avs_address_in, ch_idx(c)) &&
              rw_fmt[c] == RW_BOTH) begin
            rd_hi[c] <= !rd_hi[c];
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // System port
  // ------------------------------------------------------------
  // Writable control bits; status bits ignore writes and keep reading their inputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sys_ctrl <= SYS_CTRL_RST;
    end else if (wr_take && reg_hit(avs_address_in, IDX_SYS)) begin
      sys_ctrl <= wbyte[3:0];
    end
  end

  // Registered system outputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      speaker_out <= 1'b0;
      ram_parity_check_en_out <= 1'b1;
      io_check_en_out <= 1'b1;
    end else begin
      speaker_out <= sys_ctrl[SYS_SPK] && ch_out[2];
      ram_parity_check_en_out <= !sys_ctrl[SYS_PAR_DIS];
      io_check_en_out <= !sys_ctrl[SYS_IO_DIS];
    end
  end

  // ------------------------------------------------------------
  // Counting tick and channels
  // ------------------------------------------------------------
  scp_tick_div #(
    .DIV(TICK_CYCLES)
  ) u_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .tick_out(tick)
  );

  // Channel 2 trigger from the system port, others tied high
  assign gate[0] = 1'b1;
  assign gate[1] = 1'b1;
  assign gate[2] = sys_ctrl[SYS_GATE2];

  for (genvar g = 0; g < 3; g++) begin : g_chan
    scp_strobe_chan u_chan (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .tick_in(tick),
      .cfg_wr_in(cfg_wr[g]),
      .cfg_in(cw),
      .cnt_wr_in(cnt_wr[g]),
      .cnt_in(cnt_val[g]),
      .gate_in(gate[g]),
      .out_out(ch_out[g]),
      .count_out(count[g])
    );
  end

  assign tick_irq_out = ch_out[0];
  assign refresh_tick_out = ch_out[1];
  assign tone_out = ch_out[2];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_wait_one_cycle: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered after one wait cycle");
  chk_speaker_and: assert property (##1 speaker_out ==
    $past(sys_ctrl[SYS_SPK] && ch_out[2]))
    else $error("speaker is not bit 1 AND channel 2 output");
  chk_pair_first_byte: assert property (
    wr_take && rw_fmt[2] == RW_BOTH && !wr_hi[2] &&
    reg_hit(avs_address_in, IDX_CH2) |-> !cnt_wr[2] ##1 wr_hi[2])
    else $error("first byte of pair started a load");
  chk_ctrl_no_read: assert property (avs_read_in && avs_waitrequest_out &&
    reg_hit(avs_address_in, IDX_CTRL) |=> avs_readdata_out == 32'h0)
    else $error("control port returned data");

  // System port write seen on the bus
  sequence seq_sys_write;
    wr_take && reg_hit(avs_address_in, IDX_SYS);
  endsequence

  // System port read entering its wait cycle
  logic sys_rd_seen;
  assign sys_rd_seen = avs_read_in && avs_waitrequest_out &&
                       reg_hit(avs_address_in, IDX_SYS);

  // Check enables follow the disable bits two cycles after the write
  chk_parity_en: assert property (seq_sys_write |=> ##1
    ram_parity_check_en_out == !$past(wbyte[SYS_PAR_DIS], 2))
    else $error("parity enable does not follow bit 2");
  chk_io_en_bit: assert property (seq_sys_write |=> ##1
    io_check_en_out == !$past(wbyte[SYS_IO_DIS], 2))
    else $error("bus fault enable does not follow bit 3");
  // Control bits keep what software wrote and nothing else
  chk_sys_ctrl_store: assert property (seq_sys_write |=>
    sys_ctrl == $past(wbyte[3:0]))
    else $error("system control bits not stored");
  chk_sys_ctrl_keep: assert property (!(wr_take &&
    reg_hit(avs_address_in, IDX_SYS)) |=> $stable(sys_ctrl))
    else $error("system control bits changed without a write");
  chk_spk_off: assert property (!sys_ctrl[SYS_SPK] |=> !speaker_out)
    else $error("speaker on with bit 1 clear");

  // Status and control bits returned by a system port read
  chk_sys_par_bit: assert property (sys_rd_seen |=>
    avs_readdata_out[SYS_PAR_ERR] ==
    $past(ram_parity_err_in && !sys_ctrl[SYS_PAR_DIS]))
    else $error("system read lost board parity status");
  chk_sys_io_bit: assert property (sys_rd_seen |=>
    avs_readdata_out[SYS_IO_ERR] ==
    $past(io_check_err_in && !sys_ctrl[SYS_IO_DIS]))
    else $error("system read lost bus fault status");
  chk_sys_c2_bit: assert property (sys_rd_seen |=>
    avs_readdata_out[SYS_C2_OUT] == $past(ch_out[2]))
    else $error("system read lost channel 2 level");
  chk_sys_refresh_bit: assert property (sys_rd_seen |=>
    avs_readdata_out[SYS_REFRESH] == $past(refresh_req_in))
    else $error("system read lost refresh status");
  chk_sys_low_bits: assert property (sys_rd_seen |=>
    avs_readdata_out[3:0] == $past(sys_ctrl))
    else $error("system read lost control bits");

  // Upper read lanes stay zero; an idle bus keeps its wait
  chk_read_upper_zero: assert property (
    avs_readdata_out[31:8] == 24'h00_0000)
    else $error("read data upper bytes not zero");
  chk_idle_wait: assert property (!avs_read_in && !avs_write_in |=>
    avs_waitrequest_out)
    else $error("waitrequest dropped with no request");

  // Second byte of a pair loads the joined count
  chk_pair_second_byte: assert property (
    wr_take && rw_fmt[2] == RW_BOTH && wr_hi[2] &&
    reg_hit(avs_address_in, IDX_CH2) |->
    cnt_wr[2] && cnt_val[2] == {wbyte, lsb_hold[2]})
    else $error("second byte of pair did not load");
endmodule
`default_nettype wire
